// ==== ldsc_ahb.sv ====
`timescale 1ns/1ps
module ldsc_ahb
    import ldsc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    // decoded data phase
    output logic wr_en,
    output logic [7:0] ph_addr
);

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
    } ldsc_ap_t;

    ldsc_ap_t ap_r;
    ldsc_ap_t ap_nxt;

    // capture address phase when the bus advances
    always_comb
    begin
        ap_nxt = ap_r;
        if (hready)
        begin
            ap_nxt.wr = hsel & htrans[1] & hwrite;
            ap_nxt.addr = haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ap_r <= '0;
        else
            ap_r <= ap_nxt;
    end

    assign wr_en = ap_r.wr;
    assign ph_addr = ap_r.addr;

endmodule // ldsc_ahb

// ==== ldsc_phy_model.sv ====
`timescale 1ns/1ps
module ldsc_phy_model
(
    // clock
    input wire logic hclk,
    // event requests: col, rx, tx
    input wire logic [2:0] req,
    // event lines into the block
    output logic tx_event,
    output logic rx_event,
    output logic col_event
);
    // events follow the request one edge later, like a synchronous phy
    always_ff @(posedge hclk)
        {col_event, rx_event, tx_event} <= req;
endmodule // ldsc_phy_model

// ==== ldsc_pkg.sv ====
package ldsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] LDSC_CFG_OFS = 8'h14; // indicator_configuration
    localparam logic [7:0] LDSC_STAT_OFS = 8'h18; // live status readback
    localparam logic [15:0] LDSC_CFG_RST = 16'h0022;
    localparam logic [15:0] LDSC_CFG_WMASK = 16'h00FF; // upper byte not held

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LDSC_SEL_LSB = 4;
    localparam int LDSC_DUR_LSB = 2;
    localparam int LDSC_STR_BIT = 1;

    // ------------------------------------------------------------
    // selector codes
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_SPEED = 4'h0;
    localparam logic [3:0] SEL_TX = 4'h1;
    localparam logic [3:0] SEL_RX = 4'h2;
    localparam logic [3:0] SEL_COL = 4'h3;
    localparam logic [3:0] SEL_LINK = 4'h4;
    localparam logic [3:0] SEL_DUPLEX = 4'h5;
    localparam logic [3:0] SEL_ACT = 4'h7;
    localparam logic [3:0] SEL_ON = 4'h8;
    localparam logic [3:0] SEL_BLINK = 4'h9;
    localparam logic [3:0] SEL_LINK_RX = 4'hA;
    localparam logic [3:0] SEL_DUP_COL = 4'hF;

    // ------------------------------------------------------------
    // timing, clock 25 MHz
    // ------------------------------------------------------------
    localparam longint CLK_HZ = 25000000;
    localparam longint STR30_MS = 30;
    localparam longint STR60_MS = 60;
    localparam longint STR100_MS = 100;
    localparam longint BLINK_HALF_MS = 50;
    localparam longint STR30_CYC = STR30_MS * CLK_HZ / 1000;
    localparam longint STR60_CYC = STR60_MS * CLK_HZ / 1000;
    localparam longint STR100_CYC = STR100_MS * CLK_HZ / 1000;
    localparam longint BLINK_CYC = BLINK_HALF_MS * CLK_HZ / 1000;
    localparam int CNT_W = 22;

endpackage

// ==== ldsc_stretch.sv ====
`timescale 1ns/1ps
module ldsc_stretch
    import ldsc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic event_in,
    input wire logic [CNT_W-1:0] len,
    // result
    output logic active
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } ldsc_str_t;

    ldsc_str_t st_r;
    ldsc_str_t st_nxt;

    // reload on each event, count down to zero
    always_comb
    begin
        st_nxt = st_r;
        if (event_in)
            st_nxt.cnt = len;
        else if (st_r.cnt != '0)
            st_nxt.cnt = st_r.cnt - 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign active = event_in | (st_r.cnt != '0);

endmodule // ldsc_stretch

// ==== ldsc_top.sv ====
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module ldsc_top
    import ldsc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // transceiver status
    input wire logic speed_100,
    input wire logic tx_event,
    input wire logic rx_event,
    input wire logic col_event,
    input wire logic link_up,
    input wire logic full_duplex,
    // indicator
    output logic third_indicator
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cfg;
        logic [CNT_W-1:0] blink_cnt;
        logic blink;
        logic tgl;
        logic sec_d;
        logic led;
    } ldsc_st_t;

    ldsc_st_t st_r;
    ldsc_st_t st_nxt;

    logic wr_en;
    logic [7:0] ph_addr;
    logic [3:0] third_indicator_select;
    logic [1:0] stretch_duration_select;
    logic str_en;
    logic combined;
    logic use_str;
    logic [CNT_W-1:0] len;
    logic [2:0] ev;
    logic [2:0] ev_str;
    logic tx_v;
    logic rx_v;
    logic col_v;
    logic sec;
    logic prim;

    // ------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------
    ldsc_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .wr_en(wr_en),
        .ph_addr(ph_addr)
    );

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // read mux, unmapped reads as zero
    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (ph_addr == LDSC_CFG_OFS)
            hrdata = {16'h0000, st_r.cfg};
        else if (ph_addr == LDSC_STAT_OFS)
            hrdata = {26'h0, third_indicator, full_duplex, link_up,
                      speed_100, st_r.blink, st_r.tgl};
    end

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    assign third_indicator_select = st_r.cfg[LDSC_SEL_LSB +: 4];
    assign stretch_duration_select = st_r.cfg[LDSC_DUR_LSB +: 2];
    assign str_en = st_r.cfg[LDSC_STR_BIT];
    assign combined = (third_indicator_select == SEL_LINK_RX)
                    | (third_indicator_select == SEL_DUP_COL);
    assign use_str = str_en | combined;

    // duration decode, reserved code treated as longest
    always_comb
    begin
        unique case (stretch_duration_select)
            2'b00: len = CNT_W'(STR30_CYC);
            2'b01: len = CNT_W'(STR60_CYC);
            default: len = CNT_W'(STR100_CYC);
        endcase
    end

    // ------------------------------------------------------------
    // event stretchers: tx, rx, collision
    // ------------------------------------------------------------
    assign ev = {col_event, rx_event, tx_event};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_str
            ldsc_stretch u_str (
                .hclk(hclk),
                .hresetn(hresetn),
                .event_in(ev[gi]),
                .len(len),
                .active(ev_str[gi])
            );
        end
    endgenerate

    // stretched or raw event views
    assign tx_v = use_str ? ev_str[0] : ev[0];
    assign rx_v = use_str ? ev_str[1] : ev[1];
    assign col_v = use_str ? ev_str[2] : ev[2];

    // combined displays: secondary source and primary level
    assign sec = (third_indicator_select == SEL_DUP_COL) ? ev_str[2]
                                                         : ev_str[1];
    assign prim = (third_indicator_select == SEL_DUP_COL) ? full_duplex
                                                          : link_up;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        // software write; bit 0 kept as written, ignored
        if (wr_en && ph_addr == LDSC_CFG_OFS)
            st_nxt.cfg = hwdata[15:0] & LDSC_CFG_WMASK;
        // fast blink time base
        if (st_r.blink_cnt == '0)
        begin
            st_nxt.blink_cnt = CNT_W'(BLINK_CYC - 1);
            st_nxt.blink = ~st_r.blink;
        end
        else
            st_nxt.blink_cnt = st_r.blink_cnt - 1'b1;
        // toggle phase advances each blink tick while events stretched
        st_nxt.sec_d = sec;
        if (sec && st_r.blink_cnt == '0)
            st_nxt.tgl = ~st_r.tgl;
        else if (sec && !st_r.sec_d)
            st_nxt.tgl = ~st_r.tgl;
        else if (!sec)
            st_nxt.tgl = 1'b0;
        // source selection
        unique case (third_indicator_select)
            SEL_SPEED: st_nxt.led = speed_100;
            SEL_TX: st_nxt.led = tx_v;
            SEL_RX: st_nxt.led = rx_v;
            SEL_COL: st_nxt.led = col_v;
            SEL_LINK: st_nxt.led = link_up;
            SEL_DUPLEX: st_nxt.led = full_duplex;
            SEL_ACT: st_nxt.led = tx_v | rx_v;
            SEL_ON: st_nxt.led = 1'b1;
            SEL_BLINK: st_nxt.led = st_r.blink;
            SEL_LINK_RX:
                st_nxt.led = sec ? (prim ^ st_nxt.tgl) : link_up;
            SEL_DUP_COL:
                st_nxt.led = sec ? (prim ^ st_nxt.tgl) : full_duplex;
            default: st_nxt.led = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= '0;
            st_r.cfg <= LDSC_CFG_RST;
        end
        else
            st_r <= st_nxt;
    end

    assign third_indicator = st_r.led;

endmodule // ldsc_top

// ==== ldsc_top_assertions.sv ====
`timescale 1ns/1ps
module ldsc_top_chk
    import ldsc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // status and indicator
    input wire logic speed_100,
    input wire logic tx_event,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic third_indicator
);
    logic [15:0] cfg_s;
    logic [3:0] sel_s;
    logic wr_pend;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    assign sel_s = cfg_s[7:4];
    // shadow of the config register, loaded in the write data phase
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) wr_pend <= 1'b0;
        else wr_pend <= hsel && hready && htrans == 2'b10 && hwrite
            && haddr == LDSC_CFG_OFS;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) cfg_s <= LDSC_CFG_RST;
        else if (wr_pend) cfg_s <= hwdata[15:0] & LDSC_CFG_WMASK;
    // read address phase taken by the slave
    sequence s_rd(logic [7:0] a);
        hsel && hready && htrans == 2'b10 && !hwrite && haddr == a;
    endsequence
    property p_cfg_rd;
        s_rd(LDSC_CFG_OFS) |=> hrdata == {16'h0000, cfg_s};
    endproperty
    a_cfg_rd: assert property (p_cfg_rd)
        else $error("config readback wrong");
    property p_unmap;
        s_rd(haddr) ##0 (haddr != LDSC_CFG_OFS && haddr != LDSC_STAT_OFS)
            |=> hrdata == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_resp; !hresp && hreadyout; endproperty
    a_resp: assert property (p_resp)
        else $error("slave not ready or not okay");
    property p_on; sel_s == SEL_ON [*2] |-> third_indicator; endproperty
    a_on: assert property (p_on)
        else $error("test pattern not steady on");
    property p_speed;
        sel_s == SEL_SPEED |=> third_indicator == $past(speed_100);
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed display wrong");
    property p_tx_raw;
        sel_s == SEL_TX && !cfg_s[1] |=> third_indicator == $past(tx_event);
    endproperty
    a_tx_raw: assert property (p_tx_raw)
        else $error("unstretched transmit display wrong");
    property p_link;
        sel_s == SEL_LINK |=> third_indicator == $past(link_up);
    endproperty
    a_link: assert property (p_link)
        else $error("link display wrong");
    property p_duplex;
        sel_s == SEL_DUPLEX |=> third_indicator == $past(full_duplex);
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("duplex display wrong");
endmodule // ldsc_top_chk

bind ldsc_top ldsc_top_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .speed_100(speed_100),
    .tx_event(tx_event), .link_up(link_up), .full_duplex(full_duplex),
    .third_indicator(third_indicator));

// ==== tb_led_display_stretch_config.sv ====
`timescale 1ns/1ps
module tb_led_display_stretch_config
    import ldsc_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ind, b;
    logic speed_100, link_up, full_duplex, tx_e, rx_e, col_e;
    logic [1:0] htrans;
    logic [2:0] req;
    logic [5:0] r;
    logic [7:0] haddr;
    logic [31:0] hwdata, hrdata, rd, v;
    logic [3:0] codes [8] = '{SEL_SPEED, SEL_TX, SEL_RX, SEL_COL,
        SEL_LINK, SEL_DUPLEX, SEL_ACT, SEL_ON};
    int bad_count, check_count, cyc;
    ldsc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .speed_100(speed_100),
        .tx_event(tx_e), .rx_event(rx_e), .col_event(col_e),
        .link_up(link_up), .full_duplex(full_duplex),
        .third_indicator(ind));
    ldsc_phy_model PHY (.hclk(hclk), .req(req), .tx_event(tx_e),
        .rx_event(rx_e), .col_event(col_e));
    // 25 mhz clock
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", n, exp, got);
        end
    endtask
    task test_done;
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // single ahb-lite transfer, read data left in rd
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task setcfg(input logic [3:0] s, input logic st);
        xfer(1'b1, LDSC_CFG_OFS, {24'h0, s, 2'b01, st, 1'b0});
    endtask
    task settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask
    task pulse(input logic [2:0] p);
        @(posedge hclk);
        req <= p;
        @(posedge hclk);
        req <= 3'b000;
        settle(3);
    endtask
    function logic exp_ind(input logic [3:0] c, input logic [5:0] x);
        case (c)
            SEL_SPEED: return x[0];
            SEL_TX: return x[3];
            SEL_RX: return x[4];
            SEL_COL: return x[5];
            SEL_LINK: return x[1];
            SEL_DUPLEX: return x[2];
            SEL_ACT: return x[3] | x[4];
            SEL_ON: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction
    // hang guard
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            test_done;
        end
    end
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial
    begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, req} = '0;
        {speed_100, link_up, full_duplex} = '0;
        void'($urandom(7785));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, LDSC_CFG_OFS, 32'h0);
        chk("cfg reset", rd, 32'h0000_0022);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0000_0000);
        repeat (4)
        begin
            v = $urandom & 32'hFFFF_FFFE;
            xfer(1'b1, LDSC_CFG_OFS, v);
            xfer(1'b0, LDSC_CFG_OFS, 32'h0);
            chk("cfg rw", rd, v & {16'h0, LDSC_CFG_WMASK});
        end
        // combined displays with global stretch off
        @(posedge hclk);
        {full_duplex, link_up} <= 2'b11;
        for (int i = 0; i < 2; i++)
        begin
            setcfg(i ? SEL_DUP_COL : SEL_LINK_RX, 1'b0);
            settle(3);
            chk("primary", ind, 32'h1);
            b = ind;
            pulse(i ? 3'b100 : 3'b010);
            chk("sec", ind, !b);
            settle(100);
            chk("held", ind, !b);
        end
        // plain displays, events held as levels
        for (int i = 0; i < 16; i++)
        begin
            r = 6'($urandom);
            @(posedge hclk);
            {req, full_duplex, link_up, speed_100} <= r;
            setcfg(codes[i % 8], 1'b0);
            settle(3);
            b = exp_ind(codes[i % 8], r);
            chk("direct", ind, b);
            // live status readback: indicator, duplex, link, speed
            xfer(1'b0, LDSC_STAT_OFS, 32'h0);
            chk("status", rd[5:2], {b, r[2:0]});
        end
        // single transmit event, stretched then unstretched
        @(posedge hclk);
        req <= 3'b000;
        setcfg(SEL_TX, 1'b1);
        pulse(3'b001);
        settle(200);
        chk("stretched", ind, 32'h1);
        setcfg(SEL_TX, 1'b0);
        settle(3);
        chk("unstretched", ind, 32'h0);
        // fast blink pattern holds its level well within a half period
        setcfg(SEL_BLINK, 1'b0);
        settle(3);
        b = ind;
        settle(50);
        chk("blink hold", ind, b);
        test_done;
    end
endmodule // tb_led_display_stretch_config
